// file: logic/ptc_timer.sv
// ten bit periodic timer core with byte register port
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module ptc_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ptc_pkg::ptc_bus_req_type bus_req,
  output logic [7:0] bus_rdata,
  input wire logic sub_clk_tick,
  input wire logic timer_ext_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_output_pin,
  output logic timer_output_inverted_pin,
  output ptc_pkg::ptc_irq_type irq
);
  import ptc_pkg::*;

  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [1:0] capclr_reg;
  logic latch_edge_flag_reg;
  logic [9:0] cnt_reg;
  logic [9:0] cmp_a_reg;
  logic [9:0] cmp_b_reg;
  logic [9:0] period_reg;
  logic [7:0] buf_reg;
  logic on_prev_reg;
  logic out_reg;
  logic pulse_reg;

  logic counter_pause;
  logic [2:0] counter_clock_select;
  logic counter_on;
  logic [1:0] operating_mode_select;
  logic [1:0] pin_function_select;
  logic output_initial_level;
  logic output_polarity;
  logic capture_source_select;
  logic counter_clear_select;

  logic div4;
  logic div16;
  logic div64;
  logic ck_rise;
  logic ck_fall;
  logic pi_rise;
  logic pi_fall;
  logic src_en;
  logic tick;
  logic on_rise;
  logic a_hit;
  logic p_hit;
  logic clear_now;
  logic a_event;
  logic p_event;
  logic cap_rise;
  logic cap_fall;
  logic cap_to_a;
  logic cap_to_b;
  logic cap_clear;
  logic cap_any;
  logic wr_lo;
  logic [7:0] rd_value;

  assign counter_pause = ctrl0_reg[C0_PAUSE];
  assign counter_clock_select = ctrl0_reg[C0_CKSEL_HI:C0_CKSEL_LO];
  assign counter_on = ctrl0_reg[C0_ON];
  assign operating_mode_select = ctrl1_reg[C1_MODE_HI:C1_MODE_LO];
  assign pin_function_select = ctrl1_reg[C1_PFS_HI:C1_PFS_LO];
  assign output_initial_level = ctrl1_reg[C1_INIT];
  assign output_polarity = ctrl1_reg[C1_POL];
  assign capture_source_select = ctrl1_reg[C1_CAPSRC];
  assign counter_clear_select = ctrl1_reg[C1_CCLR];

  ptc_prescaler u_pre (
    .ref_clk(ref_clk),
    .rst(rst),
    .div4(div4),
    .div16(div16),
    .div64(div64)
  );

  ptc_edge_sync u_ck (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(timer_ext_clock_pin),
    .rise(ck_rise),
    .fall(ck_fall)
  );

  ptc_edge_sync u_pi (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(capture_input_pin),
    .rise(pi_rise),
    .fall(pi_fall)
  );

  always_comb begin
    case (counter_clock_select)
      3'b000: src_en = div4;
      3'b001: src_en = 1'b1;
      3'b010: src_en = div16;
      3'b011: src_en = div64;
      3'b100: src_en = sub_clk_tick;
      3'b101: src_en = sub_clk_tick;
      3'b110: src_en = ck_rise;
      3'b111: src_en = ck_fall;
      default: src_en = 1'b0;
    endcase
  end

  assign tick = src_en & counter_on & ~counter_pause & ~on_rise;
  assign on_rise = counter_on & ~on_prev_reg;

  assign a_hit = cnt_reg == cmp_a_reg;
  assign p_hit = (period_reg == CNT_RESET) ? (cnt_reg == CNT_MAX) :
    (cnt_reg == period_reg);

  always_comb begin
    if (operating_mode_select == MODE_COMPARE ||
        operating_mode_select == MODE_TIMER) begin
      clear_now = counter_clear_select ? a_hit : p_hit;
    end else begin
      clear_now = p_hit;
    end
  end

  assign a_event = tick & a_hit;
  assign p_event = tick & p_hit;

  assign cap_rise = capture_source_select ? ck_rise : pi_rise;
  assign cap_fall = capture_source_select ? ck_fall : pi_fall;

  always_comb begin
    cap_to_a = 1'b0;
    cap_to_b = 1'b0;
    cap_clear = 1'b0;
    if (operating_mode_select == MODE_CAPTURE && counter_on) begin
      case (pin_function_select)
        2'b00: begin
          cap_to_a = cap_rise & (capclr_reg == 2'b00);
          cap_to_b = cap_rise & (capclr_reg != 2'b00);
        end
        2'b01: begin
          cap_to_a = cap_fall;
        end
        2'b10: begin
          cap_to_a = cap_fall | (cap_rise & (capclr_reg == 2'b00));
          cap_to_b = cap_rise & (capclr_reg != 2'b00);
        end
        default: begin
          cap_to_a = 1'b0;
        end
      endcase
      case (capclr_reg)
        2'b01: cap_clear = cap_rise;
        2'b10: cap_clear = cap_fall;
        2'b11: cap_clear = cap_rise | cap_fall;
        default: cap_clear = 1'b0;
      endcase
    end
  end
  assign cap_any = cap_to_a | cap_to_b;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      on_prev_reg <= 1'b0;
    end else begin
      on_prev_reg <= counter_on;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= CNT_RESET;
    end else if (on_rise) begin
      cnt_reg <= CNT_RESET;
    end else if (cap_clear) begin
      cnt_reg <= CNT_RESET;
    end else if (tick) begin
      if (clear_now) begin
        cnt_reg <= CNT_RESET;
      end else begin
        cnt_reg <= cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= '0;
    end else begin
      irq.match_a <= a_event;
      irq.match_p <= p_event;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else if (on_rise) begin
      if (operating_mode_select == MODE_COMPARE ||
          operating_mode_select == MODE_PWM) begin
        out_reg <= output_initial_level;
      end
      pulse_reg <= 1'b1;
    end else if (operating_mode_select == MODE_COMPARE) begin
      if (a_event) begin
        case (pin_function_select)
          2'b01: out_reg <= 1'b0;
          2'b10: out_reg <= 1'b1;
          2'b11: out_reg <= ~out_reg;
          default: out_reg <= out_reg;
        endcase
      end
    end else if (operating_mode_select == MODE_PWM && counter_on) begin
      case (pin_function_select)
        2'b00: out_reg <= ~output_initial_level;
        2'b01: out_reg <= output_initial_level;
        2'b10: begin
          if (cnt_reg < cmp_a_reg) begin
            out_reg <= output_initial_level;
          end else begin
            out_reg <= ~output_initial_level;
          end
        end
        default: begin
          if (a_event) begin
            pulse_reg <= 1'b0;
            out_reg <= ~output_initial_level;
          end else if (pulse_reg) begin
            out_reg <= output_initial_level;
          end else begin
            out_reg <= ~output_initial_level;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_output_pin <= 1'b0;
      timer_output_inverted_pin <= 1'b1;
    end else begin
      timer_output_pin <= out_reg ^ output_polarity;
      timer_output_inverted_pin <= ~(out_reg ^ output_polarity);
    end
  end

  // control registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl0_reg <= CTRL0_RESET;
      ctrl1_reg <= CTRL1_RESET;
      capclr_reg <= CTRL2_RESET;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        OFF_CTRL0: ctrl0_reg <= {bus_req.wdata[7:3], 3'b000};
        OFF_CTRL1: ctrl1_reg <= bus_req.wdata;
        OFF_CTRL2: capclr_reg <= bus_req.wdata[2:1];
        default: ctrl0_reg <= ctrl0_reg;
      endcase
    end
  end

  // latch edge flag from capture
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      latch_edge_flag_reg <= 1'b0;
    end else if (cap_any) begin
      latch_edge_flag_reg <= cap_to_b | (cap_rise & ~cap_fall);
    end
  end

  // high write copies buffer
  // capture has priority over software
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmp_a_reg <= CNT_RESET;
      cmp_b_reg <= CNT_RESET;
      period_reg <= CNT_RESET;
    end else begin
      if (cap_to_a) begin
        cmp_a_reg <= cnt_reg;
      end else if (bus_req.wr && bus_req.addr == OFF_CMPA_HI) begin
        cmp_a_reg <= {bus_req.wdata[1:0], buf_reg};
      end
      if (cap_to_b) begin
        cmp_b_reg <= cnt_reg;
      end else if (bus_req.wr && bus_req.addr == OFF_CMPB_HI) begin
        cmp_b_reg <= {bus_req.wdata[1:0], buf_reg};
      end
      if (bus_req.wr && bus_req.addr == OFF_PER_HI) begin
        period_reg <= {bus_req.wdata[1:0], buf_reg};
      end
    end
  end

  assign wr_lo = bus_req.wr && (bus_req.addr == OFF_CMPA_LO ||
    bus_req.addr == OFF_CMPB_LO || bus_req.addr == OFF_PER_LO);

  // shared holding buffer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_reg <= BYTE_ZERO;
    end else if (wr_lo) begin
      buf_reg <= bus_req.wdata;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        OFF_CNT_HI: buf_reg <= cnt_reg[7:0];
        OFF_CMPA_HI: buf_reg <= cmp_a_reg[7:0];
        OFF_CMPB_HI: buf_reg <= cmp_b_reg[7:0];
        OFF_PER_HI: buf_reg <= period_reg[7:0];
        default: buf_reg <= buf_reg;
      endcase
    end
  end

  always_comb begin
    case (bus_req.addr)
      OFF_CTRL0: rd_value = {ctrl0_reg[7:3], 3'b000};
      OFF_CTRL1: rd_value = ctrl1_reg;
      OFF_CTRL2: rd_value = {5'b00000, capclr_reg, latch_edge_flag_reg};
      OFF_CNT_LO: rd_value = buf_reg;
      OFF_CMPA_LO: rd_value = buf_reg;
      OFF_CMPB_LO: rd_value = buf_reg;
      OFF_PER_LO: rd_value = buf_reg;
      OFF_CNT_HI: rd_value = {6'b000000, cnt_reg[9:8]};
      OFF_CMPA_HI: rd_value = {6'b000000, cmp_a_reg[9:8]};
      OFF_CMPB_HI: rd_value = {6'b000000, cmp_b_reg[9:8]};
      OFF_PER_HI: rd_value = {6'b000000, period_reg[9:8]};
      default: rd_value = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_rdata <= BYTE_ZERO;
    end else if (bus_req.rd) begin
      bus_rdata <= rd_value;
    end else begin
      bus_rdata <= BYTE_ZERO;
    end
  end
endmodule

// file: logic/ptc_pkg.sv
// package: register map, field positions, reset values and types of the timer
package ptc_pkg;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 10;

  localparam logic [3:0] OFF_CTRL0 = 4'h0;
  localparam logic [3:0] OFF_CTRL1 = 4'h1;
  localparam logic [3:0] OFF_CTRL2 = 4'h2;
  localparam logic [3:0] OFF_CNT_LO = 4'h3;
  localparam logic [3:0] OFF_CNT_HI = 4'h4;
  localparam logic [3:0] OFF_CMPA_LO = 4'h5;
  localparam logic [3:0] OFF_CMPA_HI = 4'h6;
  localparam logic [3:0] OFF_CMPB_LO = 4'h7;
  localparam logic [3:0] OFF_CMPB_HI = 4'h8;
  localparam logic [3:0] OFF_PER_LO = 4'h9;
  localparam logic [3:0] OFF_PER_HI = 4'hA;

  // control register 0 fields
  localparam int C0_PAUSE = 7;
  localparam int C0_CKSEL_HI = 6;
  localparam int C0_CKSEL_LO = 4;
  localparam int C0_ON = 3;
  // control register 1 fields
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_PFS_HI = 5;
  localparam int C1_PFS_LO = 4;
  localparam int C1_INIT = 3;
  localparam int C1_POL = 2;
  localparam int C1_CAPSRC = 1;
  localparam int C1_CCLR = 0;
  // control register 2 fields
  localparam int C2_CAPCLR_HI = 2;
  localparam int C2_CAPCLR_LO = 1;
  localparam int C2_FLAG = 0;

  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [1:0] CTRL2_RESET = 2'h0;
  localparam logic [9:0] CNT_RESET = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // prescaler ratios, in system clock cycles
  localparam int PRE_W = 6;
  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0F;
  localparam logic [5:0] DIV64_MASK = 6'h3F;

  localparam logic [1:0] MODE_COMPARE = 2'b00;
  localparam logic [1:0] MODE_CAPTURE = 2'b01;
  localparam logic [1:0] MODE_PWM = 2'b10;
  localparam logic [1:0] MODE_TIMER = 2'b11;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptc_bus_req_type;

  typedef struct packed {
    logic match_a;
    logic match_p;
  } ptc_irq_type;
endpackage

// file: logic/ptc_edge_sync.sv
// synchroniser and edge detector for one timer input pin
`timescale 1ns/1ps
module ptc_edge_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  import ptc_pkg::*;
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule

// file: logic/ptc_prescaler.sv
// free running prescaler giving divide by 4, 16 and 64 enables
`timescale 1ns/1ps
module ptc_prescaler (
  input wire logic ref_clk,
  input wire logic rst,
  output logic div4,
  output logic div16,
  output logic div64
);
  import ptc_pkg::*;
  logic [PRE_W-1:0] pre_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 6'h01;
    end
  end

  assign div4 = (pre_reg & DIV4_MASK) == DIV4_MASK;
  assign div16 = (pre_reg & DIV16_MASK) == DIV16_MASK;
  assign div64 = pre_reg == DIV64_MASK;
endmodule

// file: dv/ptc_far_model.sv
// far side model: count clock burst, then one capture pulse
`timescale 1ns/1ps
module ptc_far_model #(
  parameter int HALF = 4
) (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [3:0] n_edges,
  output logic ext_clk_pin,
  output logic cap_pin,
  output logic busy
);
  initial begin
    ext_clk_pin = 1'b0;
    cap_pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'b1;
        repeat (n_edges) begin
          repeat (HALF) @(posedge ref_clk);
          ext_clk_pin <= 1'b1;
          repeat (HALF) @(posedge ref_clk);
          ext_clk_pin <= 1'b0;
        end
        repeat (HALF) @(posedge ref_clk);
        cap_pin <= 1'b1;
        repeat (HALF) @(posedge ref_clk);
        cap_pin <= 1'b0;
        repeat (HALF) @(posedge ref_clk);
        busy <= 1'b0;
      end
    end
  end
endmodule

// file: dv/ptc_timer_chk.sv
// port checker for the ten bit timer
`timescale 1ns/1ps
module ptc_timer_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ptc_pkg::ptc_bus_req_type bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic timer_output_pin,
  input wire logic timer_output_inverted_pin,
  input wire ptc_pkg::ptc_irq_type irq
);
  import ptc_pkg::*;
  logic [7:0] c0_reg;
  logic [7:0] c1_reg;
  logic hi_rd;
  logic cmp_mode;
  assign hi_rd = bus_req.rd && !bus_req.addr[0]
    && bus_req.addr >= OFF_CNT_HI && bus_req.addr <= OFF_PER_HI;
  assign cmp_mode = c1_reg[7:6] == MODE_COMPARE;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // shadows of the control zero and control one writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c0_reg <= CTRL0_RESET;
      c1_reg <= CTRL1_RESET;
    end else if (bus_req.wr && bus_req.addr == OFF_CTRL0) begin
      c0_reg <= bus_req.wdata;
    end else if (bus_req.wr && bus_req.addr == OFF_CTRL1) begin
      c1_reg <= bus_req.wdata;
    end
  end
  inv_pin_a: assert property (
    timer_output_inverted_pin == !timer_output_pin)
    else $error("inverted pin equals output pin");
  rd_idle_a: assert property (
    (!bus_req.rd || bus_req.addr > OFF_PER_HI) |=> bus_rdata == BYTE_ZERO)
    else $error("read data not zero");
  hi_byte_a: assert property (hi_rd |=> bus_rdata[7:2] == 6'h00)
    else $error("high byte upper bits set");
  ctrl0_rd_a: assert property (
    bus_req.rd && bus_req.addr == OFF_CTRL0
    |=> bus_rdata == {c0_reg[7:3], 3'b000})
    else $error("control zero readback wrong");
  p_pulse_a: assert property (irq.match_p |=> !irq.match_p)
    else $error("period match longer than one cycle");
  out_level_a: assert property (
    cmp_mode && irq.match_a && c1_reg[5] != c1_reg[4]
    |=> timer_output_pin == (c1_reg[5] ^ c1_reg[C1_POL]))
    else $error("output level after match wrong");
  out_toggle_a: assert property (
    cmp_mode && irq.match_a && c1_reg[5:4] == 2'b11
    |=> timer_output_pin != $past(timer_output_pin))
    else $error("output did not toggle");
  out_restore_a: assert property (
    bus_req.wr && bus_req.addr == OFF_CTRL0 && bus_req.wdata[C0_ON]
    && !c0_reg[C0_ON] && cmp_mode
    |-> ##[1:4] timer_output_pin == (c1_reg[C1_INIT] ^ c1_reg[C1_POL]))
    else $error("output not restored on start");
endmodule
bind ptc_timer ptc_timer_chk chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .timer_output_pin(timer_output_pin),
  .timer_output_inverted_pin(timer_output_inverted_pin),
  .irq(irq)
);

// file: dv/tb_ptc_timer.sv
// self-checking bench for the ten bit timer
`timescale 1ns/1ps
module tb_ptc_timer;
  import ptc_pkg::*;
  logic ref_clk;
  logic rst;
  ptc_bus_req_type bus_req;
  logic [7:0] bus_rdata;
  logic sub_clk_tick = 1'b0;
  logic ext_pin;
  logic cap_pin;
  logic out_pin;
  logic out_inv;
  ptc_irq_type irq;
  logic go;
  logic busy;
  logic [3:0] n_edges;
  logic [2:0] sub_cnt = 3'd0;
  logic [31:0] seed;
  logic [7:0] d;
  logic [9:0] v;
  logic [9:0] w;
  logic [3:0] hi;
  int n_errors;
  int samples_checked;
  int gap;
  int divs[6] = '{4, 1, 16, 64, 5, 5};
  ptc_timer dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .sub_clk_tick(sub_clk_tick),
    .timer_ext_clock_pin(ext_pin),
    .capture_input_pin(cap_pin),
    .timer_output_pin(out_pin),
    .timer_output_inverted_pin(out_inv),
    .irq(irq)
  );
  ptc_far_model far (
    .ref_clk(ref_clk),
    .go(go),
    .n_edges(n_edges),
    .ext_clk_pin(ext_pin),
    .cap_pin(cap_pin),
    .busy(busy)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    sub_cnt <= (sub_cnt == 3'd4) ? 3'd0 : sub_cnt + 3'd1;
    sub_clk_tick <= (sub_cnt == 3'd4);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [9:0] exp_cap(input int f, input logic [3:0] n);
    return (f == 3) ? 10'h000 : {6'h00, n};
  endfunction
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [9:0] seen,
                     input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] data);
    @(posedge ref_clk);
    bus_req <= '{a, data, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] data);
    @(posedge ref_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 data = bus_rdata;
  endtask
  task automatic rd10(input logic [3:0] a, output logic [9:0] val);
    logic [7:0] h;
    logic [7:0] l;
    rd(a, h);
    rd(a - 4'h1, l);
    val = {h[1:0], l};
  endtask
  task automatic wr10(input logic [3:0] a, input logic [9:0] val);
    wr(a - 4'h1, val[7:0]);
    wr(a, {6'h00, val[9:8]});
  endtask
  task automatic wait_irq(input bit use_a, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 3000) begin
        n_errors++;
        wrap_up();
      end
    end while ((use_a ? irq.match_a : irq.match_p) !== 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    bus_req = '0;
    go = 1'b0;
    n_edges = 4'h0;
    seed = 32'hb469_6b51;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), d);
      chk("reset read", {2'b00, d}, 10'h000);
    end
    for (int p = 0; p < 3; p++) begin
      seed = lfsr(seed);
      hi = OFF_CMPA_HI + 4'(2 * p);
      wr10(hi, seed[9:0]);
      rd10(hi, w);
      chk("pair readback", w, seed[9:0]);
      wr(hi - 4'h1, ~seed[7:0]);
      rd10(hi, w);
      chk("low write buffered", w, seed[9:0]);
    end
    wr10(OFF_CNT_HI, 10'h3ff);
    rd10(OFF_CNT_HI, w);
    chk("counter write", w, 10'h000);
    wr(OFF_CTRL0, 8'hf7);
    rd(OFF_CTRL0, d);
    chk("control zero", {2'b00, d}, 10'h0f0);
    wr10(OFF_PER_HI, 10'h003);
    wr(OFF_CTRL1, 8'hc0);
    for (int k = 0; k < 6; k++) begin
      wr(OFF_CTRL0, {1'b0, 3'(k), 4'h8});
      wait_irq(1'b0, gap);
      wait_irq(1'b0, gap);
      chk("period gap", 10'(gap), 10'(4 * divs[k]));
      wr(OFF_CTRL0, 8'h00);
    end
    wr10(OFF_CMPA_HI, 10'h005);
    for (int f = 1; f < 4; f++) begin
      wr(OFF_CTRL1, {2'b00, 2'(f), 4'h9});
      wr(OFF_CTRL0, 8'h18);
      wait_irq(1'b1, gap);
      wait_irq(1'b1, gap);
      chk("compare a gap", 10'(gap), 10'd6);
      wr(OFF_CTRL0, 8'h00);
    end
    wr(OFF_CTRL1, 8'h00);
    wr10(OFF_PER_HI, 10'h000);
    wr(OFF_CTRL0, 8'h18);
    repeat (20) @(posedge ref_clk);
    wr(OFF_CTRL0, 8'h98);
    rd10(OFF_CNT_HI, v);
    repeat (7) @(posedge ref_clk);
    rd10(OFF_CNT_HI, w);
    chk("paused count", w, v);
    wr(OFF_CTRL0, 8'h10);
    rd10(OFF_CNT_HI, w);
    chk("stopped count", w, v);
    wr(OFF_CTRL0, 8'h18);
    wr(OFF_CTRL0, 8'h98);
    rd10(OFF_CNT_HI, w);
    chk("restart low", {9'h000, w < 10'd4}, 10'h001);
    for (int f = 0; f < 4; f++) begin
      wr(OFF_CTRL0, 8'h00);
      seed = lfsr(seed);
      n_edges <= seed[3:0] | 4'h2;
      wr10(OFF_CMPA_HI, 10'h000);
      wr(OFF_CTRL1, {2'b01, 2'(f), 4'h0});
      wr(OFF_CTRL0, {3'b011, f[0], 4'h8});
      @(posedge ref_clk);
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 600 && busy; i++) @(posedge ref_clk);
      if (busy) begin
        n_errors++;
        wrap_up();
      end
      rd10(OFF_CNT_HI, w);
      chk("edge count", w, {6'h00, n_edges});
      rd10(OFF_CMPA_HI, w);
      chk("captured value", w, exp_cap(f, n_edges));
    end
    wr(OFF_CTRL0, 8'h00);
    wr10(OFF_PER_HI, 10'h009);
    wr10(OFF_CMPA_HI, 10'h003);
    wr(OFF_CTRL1, 8'ha8);
    wr(OFF_CTRL0, 8'h18);
    repeat (30) @(posedge ref_clk);
    gap = 0;
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      #1 gap += out_pin;
    end
    chk("pwm high cycles", 10'(gap), 10'd3);
    wrap_up();
  end
endmodule
